// file: src/iop_port_ctrl.sv
// configurable i/o ports a..d: configuration registers, direction, address out,
// address in, data port, peripheral buffer and jtag sharing on port c.
// assumes a synchronous register strobe from the processor bus decoder and
// product terms, latched address and macrocell data from the logic arrays.
`timescale 1ns/1ps
`include "iop_params.svh"

module iop_port_ctrl
    import iop_pkg::*;
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_io_control_space_sel,
    input wire logic i_bus_wr,
    input wire logic i_bus_rd,
    input wire logic [7:0] i_bus_addr,
    input wire logic [7:0] i_bus_wdata,
    output logic [7:0] o_bus_rdata,
    input wire iop_bus_type_t i_bus_type,
    input wire logic i_data_port_mode,
    input wire logic i_jtag_en,
    input wire logic [7:0] i_jtag_out,
    input wire logic [7:0] i_jtag_oe,
    input wire iop_bank_t i_pt_oe,
    input wire iop_bank_t i_gp_out,
    input wire logic [15:0] i_addr_latched,
    input wire logic i_addr_strobe,
    input wire iop_bank_t i_decode_use,
    input wire logic i_periph_select_term_a,
    input wire logic i_periph_select_term_b,
    input wire iop_cpu_data_t i_cpu,
    input wire iop_bank_t i_pin_in,
    output iop_pad_t o_pad,
    output iop_bank_t o_imc,
    output iop_bank_t o_addr_inputs,
    output logic [7:0] o_cpu_port_rdata,
    output logic o_cpu_port_rvalid
);

    ////////////////////////////////////////////////////////////////////////////
    // configuration registers

    logic [1:0][7:0] mode_q;
    iop_bank_t dir_q;
    iop_bank_t drv_q;
    logic [7:0] memmap_q;
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;
    iop_pad_t pad_d;
    iop_pad_t pad_q;
    iop_bank_t imc_q;
    iop_bank_t addr_in_q;
    logic [7:0] port_rdata_q;
    logic port_rvalid_q;

    // write strobes, one per register
    wire bus_wr = i_io_control_space_sel && i_bus_wr;
    wire bus_rd = i_io_control_space_sel && i_bus_rd;
    wire [1:0] wr_mode = {bus_wr && (i_bus_addr == `IOP_OFS_MODE_B),
                          bus_wr && (i_bus_addr == `IOP_OFS_MODE_A)};
    wire [3:0] wr_dir = {bus_wr && (i_bus_addr == `IOP_OFS_DIR_D),
                         bus_wr && (i_bus_addr == `IOP_OFS_DIR_C),
                         bus_wr && (i_bus_addr == `IOP_OFS_DIR_B),
                         bus_wr && (i_bus_addr == `IOP_OFS_DIR_A)};
    wire [3:0] wr_drv = {bus_wr && (i_bus_addr == `IOP_OFS_DRV_D),
                         bus_wr && (i_bus_addr == `IOP_OFS_DRV_C),
                         bus_wr && (i_bus_addr == `IOP_OFS_DRV_B),
                         bus_wr && (i_bus_addr == `IOP_OFS_DRV_A)};
    wire wr_memmap = bus_wr && (i_bus_addr == `IOP_OFS_MEMMAP);

    // port d keeps only the bits that have pins
    wire [3:0][7:0] store_mask = {`IOP_PORT_D_MASK, 8'hFF, 8'hFF, 8'hFF};

    // register storage; reset clears everything
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mode_q <= {2{`IOP_CFG_RESET}};
            dir_q <= {4{`IOP_CFG_RESET}};
            drv_q <= {4{`IOP_CFG_RESET}};
            memmap_q <= `IOP_CFG_RESET;
        end else begin
            // mode registers exist on ports a and b only
            for (int p = 0; p < 2; p++) begin
                if (wr_mode[p]) begin
                    mode_q[p] <= i_bus_wdata;
                end
            end
            for (int p = 0; p < 4; p++) begin
                if (wr_dir[p]) begin
                    dir_q[p] <= i_bus_wdata & store_mask[p];
                end
                if (wr_drv[p]) begin
                    drv_q[p] <= i_bus_wdata & store_mask[p];
                end
            end
            if (wr_memmap) begin
                memmap_q <= i_bus_wdata;
            end
        end
    end

    // read decode; unmapped offsets read as zero
    assign rdata_d = (i_bus_addr == `IOP_OFS_MODE_A) ? mode_q[0] :
                     (i_bus_addr == `IOP_OFS_MODE_B) ? mode_q[1] :
                     (i_bus_addr == `IOP_OFS_DIR_A) ? dir_q[0] :
                     (i_bus_addr == `IOP_OFS_DIR_B) ? dir_q[1] :
                     (i_bus_addr == `IOP_OFS_DIR_C) ? dir_q[2] :
                     (i_bus_addr == `IOP_OFS_DIR_D) ? dir_q[3] :
                     (i_bus_addr == `IOP_OFS_DRV_A) ? drv_q[0] :
                     (i_bus_addr == `IOP_OFS_DRV_B) ? drv_q[1] :
                     (i_bus_addr == `IOP_OFS_DRV_C) ? drv_q[2] :
                     (i_bus_addr == `IOP_OFS_DRV_D) ? drv_q[3] :
                     (i_bus_addr == `IOP_OFS_MEMMAP) ? memmap_q :
                     `IOP_UNMAPPED_RD;

    // read data held until the next read
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_q <= `IOP_CFG_RESET;
        end else if (bus_rd) begin
            rdata_q <= rdata_d;
        end
    end
    assign o_bus_rdata = rdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // port-a special modes and address nibble selection

    wire periph_mode = memmap_q[`IOP_MEMMAP_PIO_BIT] && !i_data_port_mode;
    wire psel_any = i_periph_select_term_a || i_periph_select_term_b;
    wire pa_drive_bus = (i_data_port_mode || (periph_mode && psel_any))
                        && i_cpu.write_phase;
    wire pa_read_bus = (i_data_port_mode || (periph_mode && psel_any))
                       && i_cpu.read_phase;

    // nibble map: {valid, nibble index}; index 0 = a3-a0 .. 3 = a15-a12
    function automatic logic [2:0] nib_sel(input iop_bus_type_t bt, input int port,
                                           input int hi);
        logic [2:0] r;
        r = 3'h0;
        case (bt)
            IOP_BUS_MUX_GENERIC: r = {1'b1, 1'b0, hi[0]};
            IOP_BUS_PAGE_MODE: r = (port == 1) ? {1'b1, 1'b1, hi[0]} : 3'h0;
            IOP_BUS_NIBBLE_VARIANT: begin
                if (port == 0 && hi == 1) r = {1'b1, 2'h1};
                else if (port == 1 && hi == 0) r = {1'b1, 2'h2};
                else r = 3'h0;
            end
            IOP_BUS_NONMUX: r = (port == 1) ? {1'b1, 1'b0, hi[0]} : 3'h0;
            default: r = 3'h0;
        endcase
        return r;
    endfunction

    // per-port drive-select layout
    wire [3:0][7:0] od_mask = {`IOP_OD_MASK_D, `IOP_OD_MASK_C, `IOP_OD_MASK_AB,
                               `IOP_OD_MASK_AB};
    wire [3:0][7:0] slew_mask = {`IOP_SLEW_MASK_D, `IOP_SLEW_MASK_C, `IOP_SLEW_MASK_AB,
                                 `IOP_SLEW_MASK_AB};

    ////////////////////////////////////////////////////////////////////////////
    // per-pin output path

    genvar gp, gb;
    generate
        for (gp = 0; gp < 4; gp++) begin : g_port
            for (gb = 0; gb < 8; gb++) begin : g_bit
                logic [2:0] sel;
                logic amode;
                logic gen_en;
                logic gen_val;
                logic en;
                logic val;
                logic od;
                assign sel = nib_sel(i_bus_type, gp, gb / 4);
                // address out needs mode bit on ports a, b; direction is separate
                assign amode = (gp < 2) ? (mode_q[gp % 2][gb] && sel[2]) : 1'b0;
                assign gen_en = dir_q[gp][gb] || i_pt_oe[gp][gb];
                assign gen_val = amode ? i_addr_latched[{sel[1:0], 2'(gb % 4)}]
                                       : i_gp_out[gp][gb];
                if (gp == 0) begin : g_pa
                    // data port or peripheral buffer take port a over
                    assign en = (i_data_port_mode || periph_mode) ? pa_drive_bus
                                                                   : gen_en;
                    assign val = (i_data_port_mode || periph_mode) ? i_cpu.wdata[gb]
                                                                    : gen_val;
                end else if (gp == 2) begin : g_pc
                    assign en = i_jtag_en ? i_jtag_oe[gb] : gen_en;
                    assign val = i_jtag_en ? i_jtag_out[gb] : gen_val;
                end else begin : g_pbd
                    assign en = gen_en && store_mask[gp][gb];
                    assign val = gen_val;
                end
                assign od = drv_q[gp][gb] && od_mask[gp][gb];
                // open drain releases the pin instead of driving a one
                assign pad_d.dout[gp][gb] = val;
                assign pad_d.oe_n[gp][gb] = !(en && !(od && val));
                assign pad_d.open_drain[gp][gb] = od;
                assign pad_d.fast_slew[gp][gb] = drv_q[gp][gb] && slew_mask[gp][gb];
            end
        end
    endgenerate

    // pad register; all pins released at reset
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pad_q <= '{dout: '0, oe_n: '1, open_drain: '0, fast_slew: '0};
        end else begin
            pad_q <= pad_d;
        end
    end
    assign o_pad = pad_q;

    ////////////////////////////////////////////////////////////////////////////
    // address in and port-a read path

    // ports a..c latch on the strobe, port d input cells follow the pins every cycle
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            imc_q <= '0;
            addr_in_q <= '0;
        end else begin
            for (int p = 0; p < 4; p++) begin
                if (p == 3 || i_addr_strobe) begin
                    imc_q[p] <= i_pin_in[p] & store_mask[p];
                end
            end
            addr_in_q <= i_pin_in & i_decode_use;
        end
    end
    assign o_imc = imc_q;
    assign o_addr_inputs = addr_in_q;

    // port a pins onto the processor data bus when reading
    always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            port_rdata_q <= 8'h00;
            port_rvalid_q <= 1'b0;
        end else begin
            port_rvalid_q <= pa_read_bus;
            if (pa_read_bus) begin
                port_rdata_q <= i_pin_in[0];
            end
        end
    end
    assign o_cpu_port_rdata = port_rdata_q;
    assign o_cpu_port_rvalid = port_rvalid_q;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);

    sequence s_write_dir_a;
        bus_wr && i_bus_addr == `IOP_OFS_DIR_A;
    endsequence
    sequence s_read_dir_a;
        bus_rd && i_bus_addr == `IOP_OFS_DIR_A;
    endsequence

    a_dir_drives_pin: assert property (
        dir_q[3][0] |=> !o_pad.oe_n[3][0])
        else $error("port d pin 0 not driven with direction set");

    a_term_drives_pin: assert property (
        i_pt_oe[1][0] && !mode_q[1][0] |=> !o_pad.oe_n[1][0])
        else $error("oe term did not drive port b pin 0");

    a_input_default: assert property (
        !dir_q[3][1] && !i_pt_oe[3][1] |=> o_pad.oe_n[3][1])
        else $error("port d pin 1 driven without cause");

    a_port_d_upper: assert property (
        dir_q[3][7:3] == 5'h00 && o_pad.oe_n[3][7:3] == 5'h1F)
        else $error("port d pins above two active");

    a_addr_out_nib: assert property (
        i_bus_type == IOP_BUS_MUX_GENERIC && mode_q[1][6] && dir_q[1][6]
        |=> o_pad.dout[1][6] == $past(i_addr_latched[6]))
        else $error("port b pin 6 does not carry address bit 6");

    a_periph_tristate: assert property (
        periph_mode && !psel_any |=> o_pad.oe_n[0] == 8'hFF)
        else $error("peripheral buffer driven without select");

    a_data_port_drv: assert property (
        i_data_port_mode && i_cpu.write_phase
        |=> !o_pad.oe_n[0][1] && o_pad.dout[0] == $past(i_cpu.wdata))
        else $error("data port did not drive processor data");

    a_jtag_takes_pc: assert property (
        i_jtag_en |=> o_pad.dout[2] == $past(i_jtag_out))
        else $error("jtag data not on port c");

    a_reg_readback: assert property (
        s_write_dir_a ##1 (s_read_dir_a and !bus_wr)
        |=> o_bus_rdata == $past(i_bus_wdata, 2))
        else $error("direction a read back differs from write");

    a_drive_layout: assert property (
        o_pad.open_drain[0][3:0] == 4'h0 && o_pad.fast_slew[2] == 8'h00)
        else $error("drive select applied to wrong pins");

    a_imc_latch: assert property (
        i_addr_strobe |=> o_imc[1] == $past(i_pin_in[1]))
        else $error("input cell missed address strobe");

    // processor i/o value, open-drain release and slew select on the pads
    a_proc_io_value: assert property (
        !mode_q[1][0] |=> o_pad.dout[1][0] == $past(i_gp_out[1][0]))
        else $error("port b pin 0 lost its processor value");

    a_od_release: assert property (
        drv_q[0][4] && !mode_q[0][4] && !i_data_port_mode && !periph_mode && i_gp_out[0][4]
        |=> o_pad.oe_n[0][4])
        else $error("open drain pin drove a one");

    a_fast_slew: assert property (
        drv_q[3][0] |=> o_pad.fast_slew[3][0])
        else $error("port d pin 0 slew not fast");

endmodule // iop_port_ctrl

// file: src/iop_params.svh
// constants for the configurable i/o port block: register offsets, reset values,
// per-port drive-select layouts and pin counts.
// assumes offsets are relative to the base of io_control_space.
`ifndef IOP_PARAMS_SVH
`define IOP_PARAMS_SVH

// offsets inside io_control_space
`define IOP_OFS_MODE_A 8'h02
`define IOP_OFS_MODE_B 8'h03
`define IOP_OFS_DIR_A 8'h04
`define IOP_OFS_DIR_B 8'h05
`define IOP_OFS_DIR_C 8'h06
`define IOP_OFS_DIR_D 8'h07
`define IOP_OFS_DRV_A 8'h08
`define IOP_OFS_DRV_B 8'h09
`define IOP_OFS_DRV_C 8'h0A
`define IOP_OFS_DRV_D 8'h0B
`define IOP_OFS_MEMMAP 8'h10

// reset and read value of unmapped offsets
`define IOP_CFG_RESET 8'h00
`define IOP_UNMAPPED_RD 8'h00

// peripheral i/o enable bit in memory_mapping_mode_reg
`define IOP_MEMMAP_PIO_BIT 7

// which drive-select bits pick open drain, which pick slew rate
`define IOP_OD_MASK_AB 8'hF0
`define IOP_SLEW_MASK_AB 8'h0F
`define IOP_OD_MASK_C 8'hFF
`define IOP_SLEW_MASK_C 8'h00
`define IOP_OD_MASK_D 8'h00
`define IOP_SLEW_MASK_D 8'h07

// pins present on port d
`define IOP_PORT_D_MASK 8'h07

`endif

// file: src/iop_pkg.sv
// types shared by the configurable i/o port block.
// assumes the constants header supplies every number.
package iop_pkg;

    // processor bus flavour, chosen at configuration time
    typedef enum logic [1:0] {
        IOP_BUS_MUX_GENERIC,
        IOP_BUS_PAGE_MODE,
        IOP_BUS_NIBBLE_VARIANT,
        IOP_BUS_NONMUX
    } iop_bus_type_t;

    // one byte per port, index 0 = a .. 3 = d
    typedef logic [3:0][7:0] iop_bank_t;

    // everything the pad ring needs per pin
    typedef struct packed {
        iop_bank_t dout;
        iop_bank_t oe_n;
        iop_bank_t open_drain;
        iop_bank_t fast_slew;
    } iop_pad_t;

    // processor data bus as seen by port a in data-port and peripheral modes
    typedef struct packed {
        logic [7:0] wdata;
        logic write_phase;
        logic read_phase;
    } iop_cpu_data_t;

endpackage

// file: tb/iop_pin_model.sv
// far-side pin model: external peripherals and pull-ups on ports a..d.
// assumes pad outputs of the port block and one peripheral drive value per pin.
`timescale 1ns/1ps

module iop_pin_model
    import iop_pkg::*;
(
    input wire iop_pad_t i_pad,
    input wire iop_bank_t i_ext,
    output iop_bank_t o_pin
);
    ////////////////////////////////////////////////////////////////////////////
    // driven pins show the pad value, released push-pull pins the peripheral value
    always_comb begin
        for (int p = 0; p < 4; p++) begin
            for (int b = 0; b < 8; b++) begin
                if (!i_pad.oe_n[p][b]) begin
                    o_pin[p][b] = i_pad.dout[p][b];
                end else if (i_pad.open_drain[p][b]) begin
                    o_pin[p][b] = 1'b1; // released open drain sits at pull-up
                end else begin
                    o_pin[p][b] = i_ext[p][b];
                end
            end
        end
    end
endmodule // iop_pin_model

// file: tb/io_port_mode_config_test.sv
// self-checking bench for the configurable i/o port block.
// assumes the block's register strobes and a 50 MHz clock; pins come from the model.
`timescale 1ns/1ps
`include "iop_params.svh"

module io_port_mode_config_test
    import iop_pkg::*;
;
    logic clk = 0, rst_n = 0, sel = 0, wr = 0, rd = 0, dpm = 0, jen = 0;
    logic astb = 0, psa = 0, psb = 0, crv;
    logic [7:0] addr = 0, wdata = 0, rdata, jout = 0, joe = 0, crd;
    logic [15:0] alat = 16'h1234;
    iop_bus_type_t btype = IOP_BUS_MUX_GENERIC;
    iop_bank_t pt_oe = '0, gp_out = '0, dec = '0, ext = '0, pins, input_macrocell, ain;
    iop_cpu_data_t cpu = '0;
    iop_pad_t pad;
    int err_count = 0, n_checks = 0, cyc = 0;
    localparam logic [7:0] CFG[10] = '{`IOP_OFS_MODE_A, `IOP_OFS_MODE_B, `IOP_OFS_DIR_A,
        `IOP_OFS_DIR_B, `IOP_OFS_DIR_C, `IOP_OFS_DIR_D, `IOP_OFS_DRV_A, `IOP_OFS_DRV_B,
        `IOP_OFS_DRV_C, `IOP_OFS_DRV_D};
    localparam logic [7:0] EXA[4] = '{8'h34, 8'hEE, 8'h3E, 8'hEE};
    localparam logic [7:0] EXB[4] = '{8'h34, 8'h12, 8'hE2, 8'h34};

    iop_port_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_io_control_space_sel(sel), .i_bus_wr(wr),
        .i_bus_rd(rd), .i_bus_addr(addr), .i_bus_wdata(wdata), .o_bus_rdata(rdata),
        .i_bus_type(btype), .i_data_port_mode(dpm), .i_jtag_en(jen), .i_jtag_out(jout),
        .i_jtag_oe(joe), .i_pt_oe(pt_oe), .i_gp_out(gp_out), .i_addr_latched(alat),
        .i_addr_strobe(astb), .i_decode_use(dec), .i_periph_select_term_a(psa),
        .i_periph_select_term_b(psb), .i_cpu(cpu), .i_pin_in(pins), .o_pad(pad),
        .o_imc(input_macrocell), .o_addr_inputs(ain), .o_cpu_port_rdata(crd), .o_cpu_port_rvalid(crv));
    iop_pin_model pins_far (.i_pad(pad), .i_ext(ext), .o_pin(pins));

    ////////////////////////////////////////////////////////////////////////////
    // clock and hang guard
    initial begin
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc > 2000) begin
            err_count++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus and compare tasks
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        sel = 1;
        wr = 1;
        addr = a;
        wdata = d;
        @(posedge clk) #1;
        sel = 0;
        wr = 0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk) #1;
        sel = 1;
        rd = 1;
        addr = a;
        @(posedge clk) #1;
        sel = 0;
        rd = 0;
        chk8(rdata, exp, "register read");
    endtask
    task automatic settle;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // test sequence
    initial begin
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        for (int i = 0; i < 10; i++) rd_chk(CFG[i], `IOP_CFG_RESET);
        rd_chk(`IOP_OFS_MEMMAP, 8'h00);
        chk8(pad.oe_n[0], 8'hFF, "pins input after reset");
        for (int i = 0; i < 10; i++) wr_reg(CFG[i], 8'hA5);
        wr_reg(8'h1F, 8'hFF);
        for (int i = 0; i < 10; i++) rd_chk(CFG[i], (i == 5 || i == 9) ? 8'h05 : 8'hA5);
        rd_chk(8'h1F, `IOP_UNMAPPED_RD);
        // back-to-back write then read of direction a
        @(posedge clk) #1;
        sel = 1;
        wr = 1;
        addr = `IOP_OFS_DIR_A;
        wdata = 8'h3C;
        @(posedge clk) #1;
        wr = 0;
        rd = 1;
        @(posedge clk) #1;
        sel = 0;
        rd = 0;
        chk8(rdata, 8'h3C, "read right after write");
        for (int i = 0; i < 10; i++) wr_reg(CFG[i], 8'h00);
        $display("test registers done");
        // direction bit ored with oe term, bit n on pin n
        gp_out[0] = 8'h3C;
        pt_oe[0] = 8'h0F;
        wr_reg(`IOP_OFS_DIR_A, 8'h55);
        wr_reg(`IOP_OFS_DIR_D, 8'hFF);
        settle();
        chk8(pad.oe_n[0], 8'hA0, "direction or oe");
        chk8(pad.dout[0] & 8'h5F, 8'h1C, "driven value");
        chk8(pad.oe_n[3], 8'hF8, "port d three pins");
        wr_reg(`IOP_OFS_DRV_A, 8'hFF);
        wr_reg(`IOP_OFS_DRV_C, 8'hFF);
        wr_reg(`IOP_OFS_DRV_D, 8'hFF);
        settle();
        chk8(pad.open_drain[0], 8'hF0, "open drain a");
        chk8(pad.fast_slew[0], 8'h0F, "slew a");
        chk8(pad.open_drain[2], 8'hFF, "open drain c");
        chk8(pad.fast_slew[3], 8'h07, "slew d");
        chk8(pad.oe_n[0], 8'hB0, "open drain high released");
        for (int i = 0; i < 10; i++) wr_reg(CFG[i], 8'h00);
        pt_oe[0] = 8'h00;
        $display("test direction and drive done");
        // address out for every bus type
        gp_out[0] = 8'hEE;
        gp_out[1] = 8'hEE;
        wr_reg(`IOP_OFS_MODE_A, 8'hFF);
        wr_reg(`IOP_OFS_MODE_B, 8'hFF);
        wr_reg(`IOP_OFS_DIR_A, 8'hFF);
        wr_reg(`IOP_OFS_DIR_B, 8'hFF);
        for (int t = 0; t < 4; t++) begin
            btype = iop_bus_type_t'(t);
            settle();
            chk8(pad.dout[0], EXA[t], "address out a");
            chk8(pad.dout[1], EXB[t], "address out b");
        end
        btype = IOP_BUS_MUX_GENERIC;
        wr_reg(`IOP_OFS_MODE_A, 8'h00);
        settle();
        chk8(pad.dout[0], 8'hEE, "processor i/o value");
        wr_reg(`IOP_OFS_DIR_A, 8'h00);
        wr_reg(`IOP_OFS_DIR_B, 8'h00);
        $display("test address out done");
        // address inputs
        ext[0] = 8'h5A;
        astb = 1;
        @(posedge clk) #1;
        astb = 0;
        ext[0] = 8'h00;
        dec[1] = 8'h0F;
        ext[1] = 8'hC3;
        settle();
        chk8(input_macrocell[0], 8'h5A, "latched address input");
        chk8(ain[1], 8'h03, "decode address inputs");
        $display("test address in done");
        // data port overrides general i/o
        wr_reg(`IOP_OFS_DIR_A, 8'hFF);
        dpm = 1;
        ext[0] = 8'h69;
        settle();
        chk8(pad.oe_n[0], 8'hFF, "data port idle");
        cpu.wdata = 8'hC6;
        cpu.write_phase = 1;
        settle();
        chk8(pad.oe_n[0], 8'h00, "data port drive");
        chk8(pad.dout[0], 8'hC6, "data port value");
        cpu.write_phase = 0;
        @(posedge clk) #1;
        cpu.read_phase = 1;
        @(posedge clk) #1;
        cpu.read_phase = 0;
        for (int k = 0; k < 4 && crv !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk8({7'h00, crv}, 8'h01, "read valid");
        chk8(crd, 8'h69, "data port read");
        dpm = 0;
        $display("test data port done");
        // peripheral buffer
        wr_reg(`IOP_OFS_MEMMAP, 8'h80);
        cpu.write_phase = 1;
        settle();
        chk8(pad.oe_n[0], 8'hFF, "buffer without select");
        psb = 1;
        settle();
        chk8(pad.oe_n[0], 8'h00, "buffer select b");
        psb = 0;
        psa = 1;
        settle();
        chk8(pad.dout[0], 8'hC6, "buffer select a");
        chk8(pad.oe_n[0], 8'h00, "buffer select a drive");
        psa = 0;
        cpu.write_phase = 0;
        wr_reg(`IOP_OFS_MEMMAP, 8'h00);
        $display("test peripheral done");
        // jtag on port c
        jen = 1;
        joe = 8'h0F;
        jout = 8'h05;
        settle();
        chk8(pad.oe_n[2], 8'hF0, "jtag enable");
        chk8(pad.dout[2] & 8'h0F, 8'h05, "jtag value");
        jen = 0;
        settle();
        chk8(pad.oe_n[2], 8'hFF, "jtag released");
        $display("test jtag done");
        conclude();
    end
endmodule // io_port_mode_config_test
